// File: include/apsr_consts.svh
`ifndef APSR_CONSTS_SVH
`define APSR_CONSTS_SVH
// Contract
// [R1] Capture partner base ability word, read-only
// [R2] After next-page negotiation, show next-page word
// [R3] Bit 15 reports partner next-page request
// [R4] Bit 14 only from received word
// [R5] Base view bit 13 is remote fault
// [R6] Base bits 11/10 asymmetric and symmetric pause
// [R7] Base bits 9..5 report partner technologies
// [R8] Base bits 4:0 selector, reset zero
// [R9] Base bit 12 reserved, reads zero
// [R10] Next view bit 13 message page flag
// [R11] Next view bit 12 partner can comply
// [R12] Next view bit 11 inverted previous toggle
// [R13] Expansion bits 15:5 read zero, unwritable
// [R14] Expansion bit 4 parallel detect fault
// [R15] Expansion bit 3 partner next-page capable
// [R16] Expansion bit 2 constant one
// [R17] Expansion bit 1 page received, clear-on-read
// [R18] Expansion bit 0 partner negotiation capable
// [R19] Writes to read-only fields are ignored

// Register indices; the byte address is four times the index
`define APSR_IDX_PARTNER     6'h05
`define APSR_IDX_EXPANSION   6'h06
`define APSR_IDX_IRQ_STATUS  6'h08
`define APSR_IDX_IRQ_MASK    6'h09

// Partner word field positions
`define APSR_BIT_NEXT_PAGE   15
`define APSR_BIT_ACK         14
`define APSR_BIT_BP_RESERVED 12

// Expansion register field positions
`define APSR_EXP_FAULT       4
`define APSR_EXP_PARTNER_NP  3
`define APSR_EXP_LOCAL_NP    2
`define APSR_EXP_PAGE_RX     1
`define APSR_EXP_PARTNER_AN  0

// Interrupt status and mask bit positions and width
`define APSR_IRQ_PAGE        0
`define APSR_IRQ_FAULT       1
`define APSR_IRQ_DONE        2
`define APSR_IRQ_W           3

// Reset and fixed values
`define APSR_WORD_RESET      16'h0000
`define APSR_IRQ_RESET       3'h0
`define APSR_LOCAL_NP_VALUE  1'h1
`define APSR_RDATA_RESET     32'h00000000
`endif

// File: include/apsr_pkg.sv
`include "apsr_consts.svh"
package apsr_pkg;
	// Bus front end states, one-hot
	typedef enum logic [1:0] {
		apsr_bus_idle = 2'b01,
		apsr_bus_ack  = 2'b10
	} apsr_bus_fsm_t;

	// One register access as seen by the register logic
	typedef struct packed {
		logic [5:0]  index;
		logic        write;
		logic [3:0]  sel;
		logic [31:0] wdata;
	} apsr_access_t;

	// Link code word handed over by the negotiation engine
	typedef struct packed {
		logic        valid;
		logic        next;
		logic [15:0] word;
	} apsr_page_t;

	// Bus front end state
	typedef struct packed {
		apsr_bus_fsm_t fsm;
	} apsr_wb_state_t;

	// Interrupt block state
	typedef struct packed {
		logic [`APSR_IRQ_W-1:0] status;
		logic [`APSR_IRQ_W-1:0] mask;
	} apsr_irq_state_t;

	// Register bank state
	typedef struct packed {
		logic [15:0] base_word;
		logic [15:0] next_word;
		logic        next_seen;
		logic        page_rx;
		logic        fault;
		logic        partner_an;
		logic        complete;
		logic [31:0] rdata;
	} apsr_regs_state_t;
endpackage : apsr_pkg

// File: hw/apsr_wb_slave.sv
`timescale 1ns/10ps
`include "apsr_consts.svh"
module apsr_wb_slave (
	// Clock and reset
	input  wire logic             clk_in,
	input  wire logic             rst_in,
	// Wishbone request
	input  wire logic             wb_cyc_in,
	input  wire logic             wb_stb_in,
	input  wire logic             wb_we_in,
	input  wire logic [7:0]       wb_adr_in,
	input  wire logic [3:0]       wb_sel_in,
	input  wire logic [31:0]      wb_dat_in,
	// Handshake toward the register logic
	output logic                  wb_ack_out,
	output logic                  take_out,
	output apsr_pkg::apsr_access_t access_out
);
	apsr_pkg::apsr_wb_state_t state_reg;  // Registered state
	apsr_pkg::apsr_wb_state_t state_next; // Next state

	// Request fields, word index taken from the byte address
	assign access_out = {wb_adr_in[7:2], wb_we_in, wb_sel_in, wb_dat_in};
	// Acknowledge stands for exactly one cycle
	assign wb_ack_out = (state_reg.fsm == apsr_pkg::apsr_bus_ack);

	// Take a request when idle, answer in the next cycle
	always_comb begin
		state_next = state_reg;
		take_out = 1'h0;
		unique case (state_reg.fsm)
			apsr_pkg::apsr_bus_idle: begin
				// New request seen
				if (wb_cyc_in && wb_stb_in) begin
					take_out = 1'h1;
					state_next.fsm = apsr_pkg::apsr_bus_ack;
				end
			end
			apsr_pkg::apsr_bus_ack: begin
				// Ack given, back to idle in the next cycle without waiting for release
				state_next.fsm = apsr_pkg::apsr_bus_idle;
			end
			default: begin
				// Illegal code recovers to idle
				state_next.fsm = apsr_pkg::apsr_bus_idle;
			end
		endcase
	end

	// State register
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			state_reg <= '{fsm: apsr_pkg::apsr_bus_idle};
		end else begin
			state_reg <= state_next;
		end
	end
endmodule : apsr_wb_slave

// File: hw/apsr_irq.sv
`timescale 1ns/10ps
`include "apsr_consts.svh"
module apsr_irq (
	// Clock and reset
	input  wire logic                  clk_in,
	input  wire logic                  rst_in,
	// Event pulses and software writes
	input  wire logic [`APSR_IRQ_W-1:0] event_in,
	input  wire logic                  status_we_in,
	input  wire logic                  mask_we_in,
	input  wire logic [`APSR_IRQ_W-1:0] wdata_in,
	// Register views and interrupt line
	output logic [`APSR_IRQ_W-1:0]     status_out,
	output logic [`APSR_IRQ_W-1:0]     mask_out,
	output logic                       irq_out
);
	apsr_pkg::apsr_irq_state_t state_reg;  // Registered state
	apsr_pkg::apsr_irq_state_t state_next; // Next state

	assign status_out = state_reg.status;
	assign mask_out = state_reg.mask;
	// Level output while any unmasked status bit is set
	assign irq_out = |(state_reg.status & state_reg.mask);

	// Sticky status, write one to clear, new event wins
	always_comb begin
		state_next = state_reg;
		if (status_we_in) begin
			state_next.status = state_reg.status & ~wdata_in;
		end
		state_next.status = state_next.status | event_in;
		// Mask is plain read/write
		if (mask_we_in) begin
			state_next.mask = wdata_in;
		end
	end

	// State register
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			state_reg <= '{status: `APSR_IRQ_RESET, mask: `APSR_IRQ_RESET};
		end else begin
			state_reg <= state_next;
		end
	end
endmodule : apsr_irq

// File: hw/apsr_regs.sv
`timescale 1ns/10ps
`include "apsr_consts.svh"
module apsr_regs (
	// Clock and reset
	input  wire logic              clk_in,
	input  wire logic              rst_in,

	// Wishbone slave
	input  wire logic              wb_cyc_in,
	input  wire logic              wb_stb_in,
	input  wire logic              wb_we_in,
	input  wire logic [7:0]        wb_adr_in,
	input  wire logic [3:0]        wb_sel_in,
	input  wire logic [31:0]       wb_dat_in,
	output logic [31:0]            wb_dat_out,
	output logic                   wb_ack_out,

	// Negotiation engine side
	input  wire apsr_pkg::apsr_page_t page_in,
	input  wire logic              neg_complete_in,
	input  wire logic              parallel_fault_in,
	input  wire logic              partner_negotiation_capable_in,

	// Interrupt
	output logic                   irq_out
);
	// Registered bank state
	apsr_pkg::apsr_regs_state_t state_reg;
	// Next bank state
	apsr_pkg::apsr_regs_state_t state_next;

	// Access taken this cycle
	logic                          take;
	// Fields of the taken access
	apsr_pkg::apsr_access_t        access;

	// Events toward the interrupt block
	logic [`APSR_IRQ_W-1:0]        irq_event;
	// Software write strobe of the status register
	logic                          status_we;
	// Software write strobe of the mask register
	logic                          mask_we;
	// Current interrupt status
	logic [`APSR_IRQ_W-1:0]        irq_status;
	// Current interrupt mask
	logic [`APSR_IRQ_W-1:0]        irq_mask;

	// Partner register as software sees it
	logic [15:0]                   partner_view;
	// Expansion register as software sees it
	logic [15:0]                   expansion_view;
	// Next-page view selected
	logic                          show_next;
	// Read of the expansion register this cycle
	logic                          expansion_read;

	// True when an access hits a given register index
	function automatic logic hits(
		input apsr_pkg::apsr_access_t acc,
		input logic [5:0]             idx
	);
		hits = (acc.index == idx);
	endfunction : hits

	// Widen a 16-bit view onto the data bus, upper half zero
	function automatic logic [31:0] widen16(input logic [15:0] v);
		widen16 = {16'h0000, v};
	endfunction : widen16

	// Widen an interrupt field onto the data bus
	function automatic logic [31:0] widen_irq(
		input logic [`APSR_IRQ_W-1:0] v
	);
		widen_irq = {{(32 - `APSR_IRQ_W){1'h0}}, v};
	endfunction : widen_irq

	// Bus front end: decode, one-cycle ack
	apsr_wb_slave u_wb (
		.clk_in     (clk_in),
		.rst_in     (rst_in),
		.wb_cyc_in  (wb_cyc_in),
		.wb_stb_in  (wb_stb_in),
		.wb_we_in   (wb_we_in),
		.wb_adr_in  (wb_adr_in),
		.wb_sel_in  (wb_sel_in),
		.wb_dat_in  (wb_dat_in),
		.wb_ack_out (wb_ack_out),
		.take_out   (take),
		.access_out (access)
	);

	// Sticky event status with mask
	apsr_irq u_irq (
		.clk_in       (clk_in),
		.rst_in       (rst_in),
		.event_in     (irq_event),
		.status_we_in (status_we),
		.mask_we_in   (mask_we),
		.wdata_in     (access.wdata[`APSR_IRQ_W-1:0]),
		.status_out   (irq_status),
		.mask_out     (irq_mask),
		.irq_out      (irq_out)
	);

	// Read data always comes from the flip-flop
	assign wb_dat_out = state_reg.rdata;

	// Software write strobes; low byte lane carries the bits
	assign status_we = take && access.write && access.sel[0]
		&& hits(access, `APSR_IDX_IRQ_STATUS);
	assign mask_we = take && access.write && access.sel[0]
		&& hits(access, `APSR_IDX_IRQ_MASK);

	// Clear-on-read trigger for the page received flag
	assign expansion_read = take && !access.write
		&& hits(access, `APSR_IDX_EXPANSION);

	// Events: every received page, fault onset, completion onset
	always_comb begin
		irq_event = `APSR_IRQ_RESET;
		// Any link code word
		irq_event[`APSR_IRQ_PAGE] = page_in.valid;
		// Rising edge of the parallel detect fault
		irq_event[`APSR_IRQ_FAULT] = parallel_fault_in
			&& !state_reg.fault;
		// Rising edge of negotiation complete
		irq_event[`APSR_IRQ_DONE] = neg_complete_in
			&& !state_reg.complete;
	end

	// Select and assemble the two software views
	always_comb begin
		// Next page shown once complete with a next page taken
		show_next = state_reg.complete && state_reg.next_seen; // [R2]
		if (show_next) begin
			// Next-page word: request, ack, message, comply,
			// toggle and code appear as received
			partner_view = state_reg.next_word; // [R3] [R10] [R11] [R12]
		end else begin
			// Base page: request, fault, pause, technologies and
			// selector appear at their received positions
			partner_view = state_reg.base_word; // [R3] [R5] [R6] [R7] [R8]
			// Reserved bit always reads zero
			partner_view[`APSR_BIT_BP_RESERVED] = 1'h0; // [R9]
		end

		// Expansion: reserved upper bits stay zero
		expansion_view = `APSR_WORD_RESET; // [R13]
		// Parallel detection fault level
		expansion_view[`APSR_EXP_FAULT] = state_reg.fault; // [R14]
		// Partner next-page ability from its base page
		expansion_view[`APSR_EXP_PARTNER_NP] =
			state_reg.base_word[`APSR_BIT_NEXT_PAGE]; // [R15]
		// Local next-page ability is fixed
		expansion_view[`APSR_EXP_LOCAL_NP] = `APSR_LOCAL_NP_VALUE; // [R16]
		// Sticky page received flag
		expansion_view[`APSR_EXP_PAGE_RX] = state_reg.page_rx; // [R17]
		// Partner negotiation ability level
		expansion_view[`APSR_EXP_PARTNER_AN] =
			state_reg.partner_an; // [R18]
	end

	// Bank next-state logic
	always_comb begin
		state_next = state_reg;

		// Capture received link code words
		if (page_in.valid) begin
			if (page_in.next) begin
				// Next-page word, whole, ack bit included
				state_next.next_word = page_in.word; // [R4]
				state_next.next_seen = 1'h1; // [R2]
			end else begin
				// Base page, a fresh negotiation round
				state_next.base_word = page_in.word; // [R1] [R4]
				state_next.next_seen = 1'h0;
			end
		end

		// Level inputs sampled once per cycle
		state_next.fault = parallel_fault_in; // [R14]
		state_next.partner_an = partner_negotiation_capable_in; // [R18]
		state_next.complete = neg_complete_in;

		// Reading the expansion register clears the flag
		if (expansion_read) begin
			state_next.page_rx = 1'h0; // [R17]
		end
		// A page in the same cycle keeps the flag set
		if (page_in.valid) begin
			state_next.page_rx = 1'h1; // [R17]
		end

		// Read data latched when the access is taken
		if (take) begin
			if (access.write) begin
				// Writes to partner or expansion do nothing
				state_next.rdata = `APSR_RDATA_RESET; // [R19]
			end else if (hits(access, `APSR_IDX_PARTNER)) begin
				// Partner ability, current view
				state_next.rdata = widen16(partner_view); // [R1]
			end else if (hits(access, `APSR_IDX_EXPANSION)) begin
				// Expansion with value before the clear
				state_next.rdata = widen16(expansion_view); // [R13]
			end else if (hits(access, `APSR_IDX_IRQ_STATUS)) begin
				// Interrupt status
				state_next.rdata = widen_irq(irq_status);
			end else if (hits(access, `APSR_IDX_IRQ_MASK)) begin
				// Interrupt mask
				state_next.rdata = widen_irq(irq_mask);
			end else begin
				// Unmapped index reads zero
				state_next.rdata = `APSR_RDATA_RESET;
			end
		end
	end

	// Bank state register
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			// All captured words and flags start at zero
			state_reg <= '{
				base_word:  `APSR_WORD_RESET, // [R8]
				next_word:  `APSR_WORD_RESET,
				next_seen:  1'h0,
				page_rx:    1'h0,
				fault:      1'h0,
				partner_an: 1'h0,
				complete:   1'h0,
				rdata:      `APSR_RDATA_RESET
			};
		end else begin
			state_reg <= state_next;
		end
	end
endmodule : apsr_regs

// File: bench/apsr_chk.sv
`timescale 1ns/10ps
module apsr_chk (
	// Clock and reset
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	// Bus signals
	input  wire logic        wb_cyc_in,
	input  wire logic        wb_stb_in,
	input  wire logic        wb_we_in,
	input  wire logic [7:0]  wb_adr_in,
	input  wire logic [31:0] wb_dat_out,
	input  wire logic        wb_ack_out,
	// Engine levels
	input  wire logic        parallel_fault_in,
	input  wire logic        partner_negotiation_capable_in
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);
	logic [5:0] idx_reg; // Index seen at the previous edge
	logic       we_reg;  // Direction seen at the previous edge
	logic       rd_ack;  // Read answer in this cycle
	// Remember the request that the answer belongs to
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			idx_reg <= 6'h00;
			we_reg  <= 1'b0;
		end else begin
			idx_reg <= wb_adr_in[7:2];
			we_reg  <= wb_we_in;
		end
	end
	assign rd_ack = wb_ack_out && !we_reg;
	ack_pulse_a: assert property (wb_ack_out |=> !wb_ack_out)
		else $error("ack longer than one cycle");
	ack_latency_a: assert property ($rose(wb_cyc_in && wb_stb_in)
		|=> wb_ack_out) else $error("ack not one cycle after request");
	ack_cause_a: assert property (wb_ack_out
		|-> $past(wb_cyc_in && wb_stb_in)) else $error("ack unasked");
	write_zero_a: assert property (wb_ack_out && we_reg
		|-> wb_dat_out == 32'h0) else $error("write returned data");
	unmapped_zero_a: assert property (rd_ack && !(idx_reg inside
		{6'h05, 6'h06, 6'h08, 6'h09}) |-> wb_dat_out == 32'h0)
		else $error("unmapped read not zero");
	dat_hold_a: assert property (!wb_cyc_in |=> $stable(wb_dat_out))
		else $error("read data moved while idle");
	exp_fixed_a: assert property (rd_ack && idx_reg == 6'h06
		|-> wb_dat_out[2] && wb_dat_out[31:5] == 27'h0)
		else $error("expansion fixed bits wrong");
	exp_levels_a: assert property (rd_ack && idx_reg == 6'h06
		|-> wb_dat_out[4] == $past(parallel_fault_in, 2)
		&& wb_dat_out[0] == $past(partner_negotiation_capable_in, 2))
		else $error("expansion levels wrong");
	part_upper_a: assert property (rd_ack && idx_reg == 6'h05
		|-> wb_dat_out[31:16] == 16'h0) else $error("partner upper bits");
endmodule : apsr_chk
bind apsr_regs apsr_chk apsr_chk_inst (.clk_in(clk_in), .rst_in(rst_in),
	.wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in),
	.wb_adr_in(wb_adr_in), .wb_dat_out(wb_dat_out),
	.wb_ack_out(wb_ack_out), .parallel_fault_in(parallel_fault_in),
	.partner_negotiation_capable_in(partner_negotiation_capable_in));

// File: bench/apsr_partner.sv
`timescale 1ns/10ps
module apsr_partner (
	// Clock
	input  wire logic            clk_in,
	// Received words and status levels
	output apsr_pkg::apsr_page_t page_out,
	output logic                 done_out,
	output logic                 fault_out,
	output logic                 an_out
);
	// Quiet link at time zero
	initial begin
		page_out  = '0;
		done_out  = 1'b0;
		fault_out = 1'b0;
		an_out    = 1'b0;
	end
	// One received word, valid for one cycle; ack bit as sent
	task automatic send(input logic nxt, input logic [15:0] w);
		@(posedge clk_in);
		page_out <= {1'b1, nxt, w};
		@(posedge clk_in);
		// Stale word replaced by its inverse
		page_out <= {1'b0, ~nxt, ~w};
	endtask : send
	// Negotiation status levels
	task automatic levels(input logic d, input logic f, input logic a);
		@(posedge clk_in);
		done_out  <= d;
		fault_out <= f;
		an_out    <= a;
	endtask : levels
endmodule : apsr_partner

// File: bench/apsr_regs_bench.sv
`timescale 1ns/10ps
module apsr_regs_bench;
	logic                 clk_in, rst_in;     // Clock and reset
	logic                 cyc, stb, we, ack;  // Bus control
	logic [7:0]           adr;                // Byte address
	logic [3:0]           sel;                // Byte enables
	logic [31:0]          wdat, dout, rdat;   // Bus data
	logic                 irq, done, fault, an; // Status lines
	apsr_pkg::apsr_page_t page;               // Received word
	int                   failures, cmp_count; // Tallies
	apsr_regs apsr_regs_inst (.clk_in(clk_in), .rst_in(rst_in),
		.wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
		.wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(dout),
		.wb_ack_out(ack), .page_in(page), .neg_complete_in(done),
		.parallel_fault_in(fault), .partner_negotiation_capable_in(an),
		.irq_out(irq));
	apsr_partner apsr_partner_inst (.clk_in(clk_in), .page_out(page),
		.done_out(done), .fault_out(fault), .an_out(an));
	// Free-running clock
	initial begin
		clk_in = 1'b0;
		forever #12.5 clk_in = ~clk_in;
	end
	// Verdict and end of run
	task automatic wrap_up;
		if (failures == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : wrap_up
	// Compare seen against expected
	task automatic chk(input string nm, input logic [31:0] got, exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	// One classic Wishbone cycle, held until ack
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		@(posedge clk_in);
		cyc  <= 1'b1;
		stb  <= 1'b1;
		we   <= w;
		adr  <= a;
		wdat <= d;
		n = 0;
		do begin
			@(posedge clk_in);
			n++;
		end while (ack !== 1'b1 && n < 40);
		if (n >= 40) begin
			failures++;
			wrap_up();
		end else begin
			rdat = dout;
			cyc <= 1'b0;
			stb <= 1'b0;
		end
	endtask : bus
	// Read and compare
	task automatic rd(input string nm, input logic [7:0] a,
		input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(nm, rdat, e);
	endtask : rd
	// Main sequence
	initial begin
		{cyc, stb, we, adr, wdat, failures, cmp_count} = '0;
		sel = 4'hF;
		rst_in = 1'b1;
		repeat (12) @(posedge clk_in);
		rst_in <= 1'b0;
		rd("part_rst", 8'h14, 32'h0);
		rd("exp_rst", 8'h18, 32'h4);
		rd("unmapped", 8'h3C, 32'h0);
		bus(1'b1, 8'h3C, 32'hFFFF);
		apsr_partner_inst.send(1'b0, 16'hF7E5);
		rd("base", 8'h14, 32'hE7E5);
		rd("exp_page", 8'h18, 32'hE);
		rd("exp_cor", 8'h18, 32'hC);
		bus(1'b1, 8'h14, 32'h0);
		bus(1'b1, 8'h18, 32'hFFFF);
		rd("base_wr", 8'h14, 32'hE7E5);
		rd("exp_wr", 8'h18, 32'hC);
		apsr_partner_inst.levels(1'b0, 1'b1, 1'b1);
		rd("exp_lvl", 8'h18, 32'h1D);
		apsr_partner_inst.send(1'b1, 16'h5ABC);
		rd("np_early", 8'h14, 32'hE7E5);
		rd("exp_np", 8'h18, 32'h1F);
		apsr_partner_inst.levels(1'b1, 1'b1, 1'b1);
		rd("np_view", 8'h14, 32'h5ABC);
		apsr_partner_inst.send(1'b0, 16'h0421);
		rd("base2", 8'h14, 32'h0421);
		rd("exp_b2", 8'h18, 32'h17);
		apsr_partner_inst.send(1'b1, 16'hA7FF);
		rd("np2", 8'h14, 32'hA7FF);
		rd("irq_st", 8'h20, 32'h7);
		chk("irq_off", {31'h0, irq}, 32'h0);
		bus(1'b1, 8'h24, 32'h1);
		chk("irq_on", {31'h0, irq}, 32'h1);
		rd("irq_mask", 8'h24, 32'h1);
		bus(1'b1, 8'h20, 32'h7);
		chk("irq_clr", {31'h0, irq}, 32'h0);
		rd("irq_st0", 8'h20, 32'h0);
		apsr_partner_inst.send(1'b0, 16'h0001);
		rd("irq_st1", 8'h20, 32'h1);
		chk("irq_ev", {31'h0, irq}, 32'h1);
		bus(1'b1, 8'h24, 32'h0);
		chk("irq_msk", {31'h0, irq}, 32'h0);
		// Mask write with its byte lane off is ignored
		sel <= 4'hE;
		bus(1'b1, 8'h24, 32'h7);
		sel <= 4'hF;
		rd("mask_lane", 8'h24, 32'h0);
		// New page in the cycle of the status clear keeps the bit
		fork
			apsr_partner_inst.send(1'b0, 16'h0001);
			bus(1'b1, 8'h20, 32'h1);
		join
		rd("irq_keep", 8'h20, 32'h1);
		rd("exp_pre", 8'h18, 32'h17);
		// New page in the cycle of the clearing read sets the flag
		fork
			apsr_partner_inst.send(1'b0, 16'h8001);
			rd("exp_sw", 8'h18, 32'h15);
		join
		rd("exp_keep", 8'h18, 32'h1F);
		// Second reset in mid-run, bus idle
		@(posedge clk_in);
		rst_in <= 1'b1;
		repeat (2) @(posedge clk_in);
		rst_in <= 1'b0;
		rd("part_rst2", 8'h14, 32'h0);
		rd("exp_rst2", 8'h18, 32'h15);
		rd("mask_rst", 8'h24, 32'h0);
		chk("irq_rst", {31'h0, irq}, 32'h0);
		wrap_up();
	end
endmodule : apsr_regs_bench
